// >>> pkg/fmasu_pkg.sv
/*
 Shared constants and types of the floating-point move, arithmetic and stack unit.
 Assumes 32-bit words and a byte-addressed Avalon-MM register window.
*/
package fmasu_pkg;
	localparam int unsigned ADDR_W = 5;
	// Register window byte offsets
	localparam logic [4:0] OFS_CMD   = 5'h00;
	localparam logic [4:0] OFS_STAT  = 5'h04;
	localparam logic [4:0] OFS_FP_STATUS_CONTROL_REG = 5'h08;
	localparam logic [4:0] OFS_IDX   = 5'h0c;
	localparam logic [4:0] OFS_CORE  = 5'h10;
	localparam logic [4:0] OFS_FPR   = 5'h14;
	localparam logic [4:0] OFS_MEM   = 5'h18;
	// Command word fields
	localparam int unsigned CMD_OP_LSB  = 0;
	localparam int unsigned CMD_SKIP    = 4;
	localparam int unsigned CMD_RA_LSB  = 5;
	localparam int unsigned CMD_RB_LSB  = 10;
	localparam int unsigned CMD_RC_LSB  = 15;
	localparam int unsigned CMD_RT_LSB  = 20;
	localparam int unsigned CMD_RT2_LSB = 24;
	localparam int unsigned CMD_DBL     = 28;
	localparam int unsigned CMD_DB      = 29;
	localparam int unsigned CMD_WB      = 30;
	localparam int unsigned CMD_DIR     = 31;
	// Status word fields
	localparam int unsigned STAT_BUSY     = 0;
	localparam int unsigned STAT_ERR      = 1;
	localparam int unsigned STAT_NZCV_LSB = 4;
	localparam int unsigned FP_STATUS_CONTROL_REG_NZCV_LSB = 28;
	localparam int unsigned SIGN_BIT       = 31;
	// Reset values and fixed figures
	localparam logic [31:0] FP_STATUS_CONTROL_REG_RST   = 32'h0000_0000;
	localparam logic [31:0] REG_RST     = 32'h0000_0000;
	localparam logic [31:0] DEFAULT_NAN = 32'h7fc0_0000;
	localparam logic [3:0]  SP_REG      = 4'hd;
	localparam logic [3:0]  FLAG_TARGET = 4'hf;
	localparam logic [4:0]  LIST_MAX    = 5'h10;
	localparam logic [4:0]  SQRT_LAST   = 5'h17;
	localparam logic [5:0]  FP_WORDS    = 6'h20;

	typedef enum logic [3:0] {
		op_pair_xfer               = 4'h0,
		op_dbl_xfer                = 4'h1,
		op_scalar_xfer             = 4'h2,
		op_single_xfer             = 4'h3,
		op_fp_status_read          = 4'h4,
		op_fp_status_write         = 4'h5,
		op_fp_multiply             = 4'h6,
		op_fp_negate               = 4'h7,
		op_fp_neg_multiply_add     = 4'h8,
		op_fp_neg_multiply_sub     = 4'h9,
		op_fp_neg_multiply         = 4'ha,
		op_fp_square_root          = 4'hb,
		op_fp_stack_pop            = 4'hc,
		op_fp_stack_push           = 4'hd,
		op_fp_store_multiple       = 4'he
	} fmasu_op_t;

	typedef enum logic [1:0] {ar_mul = 2'h0, ar_mac = 2'h1, ar_sqrt = 2'h2} fmasu_aop_t;

	// Gray order: idle, exec, arith, mem; arith and mem return to idle
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_exec  = 2'b01,
		st_arith = 2'b11,
		st_mem   = 2'b10
	} fmasu_state_t;
endpackage

// >>> pkg/fmasu_arith_if.sv
/*
 Request and answer bundle between the unit's sequencer and its arithmetic core.
 Assumes both ends share one clock; start is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
interface fmasu_arith_if;
	import fmasu_pkg::*;
	logic        start;
	fmasu_aop_t  op;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] c;
	logic        done;
	logic [31:0] res;
	modport seq  (output start, output op, output a, output b, output c,
		input done, input res);
	modport unit (input start, input op, input a, input b, input c,
		output done, output res);
endinterface
`default_nettype wire

// >>> verilog/fmasu_arith.sv
/*
 Single-precision multiply, multiply-add and iterative square root.
 Assumes operands stand only in the start cycle; denormals flush to zero.
*/
`timescale 1ns/1ps
`default_nettype none
module fmasu_arith (
	input wire logic    clk,
	input wire logic    arst_n,
	fmasu_arith_if.unit io
);
	import fmasu_pkg::*;

	logic        busy_q, busy_d, done_q, done_d;
	logic [4:0]  step_q, step_d;
	logic [47:0] rad_q, rad_d;
	logic [23:0] root_q, root_d;
	logic [7:0]  exp_q, exp_d;
	logic [31:0] res_q, res_d;

	// Truncating product, saturating to infinity on overflow
	function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
		logic [47:0] p;
		logic [9:0]  e;
		logic        s;
		s = x[31] ^ y[31];
		p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
		e = {2'b00, x[30:23]} + {2'b00, y[30:23]} - 10'h07f + {9'h000, p[47]};
		if (x[30:23] == 8'h00 || y[30:23] == 8'h00 || e[9] || e == 10'h000)
			return {s, 31'h0};
		if (e >= 10'h0ff)
			return {s, 8'hff, 23'h0};
		return {s, e[7:0], p[47] ? p[46:24] : p[45:23]};
	endfunction

	// Aligned add of signed magnitudes, one guard bit
	function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
		logic [31:0] g, l;
		logic [7:0]  d;
		logic [25:0] sm;
		logic [8:0]  e;
		if (x[30:0] >= y[30:0]) begin
			g = x;
			l = y;
		end else begin
			g = y;
			l = x;
		end
		if (l[30:23] == 8'h00)
			return (g[30:23] == 8'h00) ? 32'h0 : g;
		d = g[30:23] - l[30:23];
		sm = (d > 8'h19) ? 26'h0 : ({2'b01, l[22:0], 1'b0} >> d);
		sm = (g[31] == l[31]) ? {2'b01, g[22:0], 1'b0} + sm : {2'b01, g[22:0], 1'b0} - sm;
		e = {1'b0, g[30:23]};
		if (sm == 26'h0)
			return 32'h0;
		if (sm[25]) begin
			sm = sm >> 1;
			e = e + 9'h001;
		end
		for (int i = 0; i < 24; i++) begin
			if (!sm[24] && e != 9'h000) begin
				sm = sm << 1;
				e = e - 9'h001;
			end
		end
		if (e == 9'h000)
			return {g[31], 31'h0};
		if (e >= 9'h0ff)
			return {g[31], 8'hff, 23'h0};
		return {g[31], e[7:0], sm[23:1]};
	endfunction

	// Next state: one-cycle products, one root bit per cycle
	always_comb begin
		logic [23:0] trial;
		logic [47:0] sq;
		trial = 24'h0;
		sq = 48'h0;
		busy_d = busy_q;
		done_d = 1'b0;
		step_d = step_q;
		rad_d = rad_q;
		root_d = root_q;
		exp_d = exp_q;
		res_d = res_q;
		if (io.start) begin
			case (io.op)
				ar_mul: begin
					res_d = fmul(io.a, io.b);
					done_d = 1'b1;
				end
				ar_mac: begin
					res_d = fadd(fmul(io.a, io.b), io.c);
					done_d = 1'b1;
				end
				default: begin
					if (io.a[30:23] == 8'h00) begin
						res_d = {io.a[31], 31'h0};
						done_d = 1'b1;
					end else if (io.a[31]) begin
						res_d = DEFAULT_NAN;
						done_d = 1'b1;
					end else begin
						busy_d = 1'b1;
						step_d = SQRT_LAST;
						root_d = 24'h0;
						exp_d = 8'((9'(io.a[30:23]) + 9'h07f) >> 1);
						rad_d = io.a[23] ? {1'b0, 1'b1, io.a[22:0], 23'h0}
							: {1'b1, io.a[22:0], 24'h0};
					end
				end
			endcase
		end else if (busy_q) begin
			trial = root_q | (24'h1 << step_q);
			sq = trial * trial;
			if (sq <= rad_q)
				root_d = trial;
			if (step_q == 5'h00) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				res_d = {1'b0, exp_q, root_d[22:0]};
			end else begin
				step_d = step_q - 5'h01;
			end
		end
	end

	// Register the arithmetic state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			step_q <= 5'h00;
			rad_q <= 48'h0;
			root_q <= 24'h0;
			exp_q <= 8'h00;
			res_q <= REG_RST;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			step_q <= step_d;
			rad_q <= rad_d;
			root_q <= root_d;
			exp_q <= exp_d;
			res_q <= res_d;
		end
	end

	assign io.done = done_q;
	assign io.res = res_q;
endmodule
`default_nettype wire

// >>> verilog/fmasu_top.sv
/*
 Floating-point move, arithmetic and stack unit with its register files and memory.
 Assumes an Avalon-MM master with waitrequest; one command runs at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module fmasu_top #(
	parameter int unsigned MEM_WORDS = 64
) (
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire logic [fmasu_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest
);
	import fmasu_pkg::*;
	localparam int unsigned MEM_AW = $clog2(MEM_WORDS);

	// Memory must be a power of two so address bits index it directly
	if (MEM_WORDS < 2 || MEM_WORDS > 65536 || (MEM_WORDS & (MEM_WORDS - 1)) != 0)
		$error("MEM_WORDS must be a power of two from 2 to 65536");

	logic [31:0]   core_q [16];
	logic [31:0]   fp_q [32];
	logic [31:0]   mem_q [MEM_WORDS];
	fmasu_state_t  st_q, st_d;
	logic [31:0]   cmd_q, cmd_d, idx_q, idx_d, fp_status_control_reg_q, fp_status_control_reg_d, rdata_q, rdata_d;
	logic [31:0]   addr_q, addr_d;
	logic [3:0]    apsr_q, apsr_d;
	logic [5:0]    cnt_q, cnt_d;
	logic [4:0]    fw_q, fw_d;
	logic          ack_q, ack_d, err_q, err_d, busy;
	logic          c_we0, c_we1, f_we0, f_we1, m_we;
	logic [3:0]    c_wa0, c_wa1;
	logic [4:0]    f_wa0, f_wa1;
	logic [MEM_AW-1:0] m_wa;
	logic [31:0]   c_wd0, c_wd1, f_wd0, f_wd1, m_wd;
	fmasu_arith_if ar_if ();

	// Command fields
	fmasu_op_t   op;
	logic [4:0]  ra, rb, rc, ra_p1, dlo, dhi, sel_half, keep_half;
	logic [3:0]  rt, rt2, base_idx;
	logic        skip, dbl, dec_b, wback, dir, down, list_ok;
	logic [31:0] rt_val, rt2_val, sa_val, sa1_val, sb_val, sc_val, base_val, span;
	logic [5:0]  words;
	assign op = fmasu_op_t'(cmd_q[CMD_OP_LSB +: 4]);
	assign ra = cmd_q[CMD_RA_LSB +: 5];
	assign rb = cmd_q[CMD_RB_LSB +: 5];
	assign rc = cmd_q[CMD_RC_LSB +: 5];
	assign rt = cmd_q[CMD_RT_LSB +: 4];
	assign rt2 = cmd_q[CMD_RT2_LSB +: 4];
	assign skip = cmd_q[CMD_SKIP];
	assign dbl = cmd_q[CMD_DBL];
	assign dec_b = cmd_q[CMD_DB];
	assign wback = cmd_q[CMD_WB];
	assign dir = cmd_q[CMD_DIR];
	assign ra_p1 = ra + 5'h01;
	assign dlo = {ra[3:0], 1'b0};
	assign dhi = {ra[3:0], 1'b1};
	assign sel_half = {ra[3:0], dbl};
	assign keep_half = {ra[3:0], ~dbl};
	assign rt_val = core_q[rt];
	assign rt2_val = core_q[rt2];
	assign sa_val = fp_q[ra];
	assign sa1_val = fp_q[ra_p1];
	assign sb_val = fp_q[rb];
	assign sc_val = fp_q[rc];
	// Stack forms always use SP; store-multiple uses its own base
	assign base_idx = (op == op_fp_stack_pop || op == op_fp_stack_push) ? SP_REG : rt;
	assign base_val = core_q[base_idx];
	assign words = dbl ? {rc, 1'b0} : {1'b0, rc};
	assign span = {24'h0, words, 2'b00};
	assign down = (op == op_fp_stack_push) || (op == op_fp_store_multiple && dec_b);
	// list length 1 to 16, no wrap past the last single
	assign list_ok = rc != 5'h00 && rc <= LIST_MAX && ({1'b0, dbl ? dlo : ra} + words) <= FP_WORDS;
	assign busy = st_q != st_idle;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = n[8*i +: 8];
		end
		return r;
	endfunction

	// Bus answers one cycle after the request; writes wait while busy
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;

	// Arithmetic requests come straight from the exec cycle
	always_comb begin
		ar_if.start = st_q == st_exec && !skip && (op == op_fp_multiply
			|| op == op_fp_neg_multiply_add || op == op_fp_neg_multiply_sub
			|| op == op_fp_neg_multiply || op == op_fp_square_root);
		ar_if.op = (op == op_fp_square_root) ? ar_sqrt
			: (op == op_fp_neg_multiply_add || op == op_fp_neg_multiply_sub) ? ar_mac : ar_mul;
		ar_if.a = (op == op_fp_square_root) ? sc_val : sb_val;
		ar_if.b = sc_val;
		ar_if.c = sa_val ^ ((op == op_fp_neg_multiply_sub) ? 32'h8000_0000 : 32'h0);
	end

	fmasu_arith u_arith (
		.clk    (clk),
		.arst_n (arst_n),
		.io     (ar_if)
	);

	// Next values of the bus slave, sequencer and register-file write ports
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		fp_status_control_reg_d = fp_status_control_reg_q;
		apsr_d = apsr_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		fw_d = fw_q;
		err_d = err_q;
		rdata_d = rdata_q;
		ack_d = (avs_read || (avs_write && !busy)) && !ack_q;
		{c_we0, c_we1, f_we0, f_we1, m_we} = 5'h00;
		{c_wa0, c_wa1} = 8'h00;
		{f_wa0, f_wa1} = 10'h000;
		m_wa = '0;
		{c_wd0, c_wd1, f_wd0, f_wd1, m_wd} = {5{32'h0}};
		if (ack_d && avs_read) begin
			case (avs_address)
				OFS_CMD:   rdata_d = cmd_q;
				OFS_STAT:  rdata_d = {24'h0, apsr_q, 2'b00, err_q, busy};
				OFS_FP_STATUS_CONTROL_REG: rdata_d = fp_status_control_reg_q;
				OFS_IDX:   rdata_d = idx_q;
				OFS_CORE:  rdata_d = core_q[idx_q[3:0]];
				OFS_FPR:   rdata_d = fp_q[idx_q[4:0]];
				OFS_MEM:   rdata_d = mem_q[idx_q[MEM_AW-1:0]];
				default:   rdata_d = 32'h0;
			endcase
		end
		// Write takes effect at the edge where waitrequest is low
		if (ack_q && avs_write) begin
			case (avs_address)
				OFS_CMD: begin
					cmd_d = be_merge(cmd_q, avs_writedata, avs_byteenable);
					err_d = 1'b0;
					st_d = st_exec;
				end
				OFS_IDX: idx_d = be_merge(idx_q, avs_writedata, avs_byteenable);
				OFS_CORE: begin
					c_we0 = 1'b1;
					c_wa0 = idx_q[3:0];
					c_wd0 = be_merge(core_q[idx_q[3:0]], avs_writedata, avs_byteenable);
				end
				OFS_FPR: begin
					f_we0 = 1'b1;
					f_wa0 = idx_q[4:0];
					f_wd0 = be_merge(fp_q[idx_q[4:0]], avs_writedata, avs_byteenable);
				end
				OFS_MEM: begin
					m_we = 1'b1;
					m_wa = idx_q[MEM_AW-1:0];
					m_wd = be_merge(mem_q[idx_q[MEM_AW-1:0]], avs_writedata, avs_byteenable);
				end
				default: ;
			endcase
		end
		case (st_q)
			st_idle: ;
			st_exec: begin
				st_d = st_idle;
				if (!skip) begin
					case (op)
						op_pair_xfer: begin
							c_we0 = dir;
							c_wa0 = rt;
							c_wd0 = sa_val;
							c_we1 = dir;
							c_wa1 = rt2;
							c_wd1 = sa1_val;
							f_we0 = !dir;
							f_wa0 = ra;
							f_wd0 = rt_val;
							f_we1 = !dir;
							f_wa1 = ra_p1;
							f_wd1 = rt2_val;
						end
						op_dbl_xfer: begin
							// two words to or from one double
							c_we0 = dir;
							c_wa0 = rt;
							c_wd0 = fp_q[dlo];
							c_we1 = dir;
							c_wa1 = rt2;
							c_wd1 = fp_q[dhi];
							f_we0 = !dir;
							f_wa0 = dlo;
							f_wd0 = rt_val;
							f_we1 = !dir;
							f_wa1 = dhi;
							f_wd1 = rt2_val;
						end
						op_scalar_xfer: begin
							// only the selected half is written
							c_we0 = dir;
							c_wa0 = rt;
							c_wd0 = fp_q[sel_half];
							f_we0 = !dir;
							f_wa0 = sel_half;
							f_wd0 = rt_val;
						end
						op_single_xfer: begin
							c_we0 = dir;
							c_wa0 = rt;
							c_wd0 = sa_val;
							f_we0 = !dir;
							f_wa0 = ra;
							f_wd0 = rt_val;
						end
						op_fp_status_read: begin
							// flag form targets the application flags
							if (rt == FLAG_TARGET) begin
								apsr_d = fp_status_control_reg_q[FP_STATUS_CONTROL_REG_NZCV_LSB +: 4];
							end else begin
								c_we0 = 1'b1;
								c_wa0 = rt;
								c_wd0 = fp_status_control_reg_q;
							end
						end
						op_fp_status_write: fp_status_control_reg_d = rt_val;
						op_fp_negate: begin
							f_we0 = 1'b1;
							f_wa0 = ra;
							f_wd0 = sc_val ^ 32'h8000_0000;
						end
						op_fp_multiply, op_fp_neg_multiply_add, op_fp_neg_multiply_sub,
						op_fp_neg_multiply, op_fp_square_root: st_d = st_arith;
						op_fp_stack_pop, op_fp_stack_push, op_fp_store_multiple: begin
							// bad list length is refused whole
							if (!list_ok) begin
								err_d = 1'b1;
							end else begin
								st_d = st_mem;
								cnt_d = words;
								fw_d = dbl ? dlo : ra;
								// upward from base, or from base minus span when decrementing
								addr_d = down ? base_val - span : base_val;
								// base updated by the whole span; store-multiple only with writeback
								c_we0 = op != op_fp_store_multiple || wback;
								c_wa0 = base_idx;
								c_wd0 = down ? base_val - span : base_val + span;
							end
						end
						default: err_d = 1'b1;
					endcase
				end
			end
			st_arith: begin
				if (ar_if.done) begin
					f_we0 = 1'b1;
					f_wa0 = ra;
					f_wd0 = ar_if.res ^ ((op == op_fp_neg_multiply_add
						|| op == op_fp_neg_multiply) ? 32'h8000_0000 : 32'h0);
					st_d = st_idle;
				end
			end
			st_mem: begin
				// one word per cycle, lowest register at lowest address
				if (op == op_fp_stack_pop) begin
					f_we0 = 1'b1;
					f_wa0 = fw_q;
					f_wd0 = mem_q[addr_q[MEM_AW+1:2]];
				end else begin
					m_we = 1'b1;
					m_wa = addr_q[MEM_AW+1:2];
					m_wd = fp_q[fw_q];
				end
				addr_d = addr_q + 32'h4;
				fw_d = fw_q + 5'h01;
				cnt_d = cnt_q - 6'h01;
				if (cnt_q == 6'h01)
					st_d = st_idle;
			end
			default: st_d = st_idle;
		endcase
	end

	// Control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= st_idle;
			cmd_q <= REG_RST;
			idx_q <= REG_RST;
			fp_status_control_reg_q <= FP_STATUS_CONTROL_REG_RST;
			apsr_q <= 4'h0;
			addr_q <= REG_RST;
			cnt_q <= 6'h00;
			fw_q <= 5'h00;
			err_q <= 1'b0;
			rdata_q <= REG_RST;
			ack_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			fp_status_control_reg_q <= fp_status_control_reg_d;
			apsr_q <= apsr_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			fw_q <= fw_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// Register files; port 1 wins when both name the same register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 16; i++)
				core_q[i] <= REG_RST;
			for (int i = 0; i < 32; i++)
				fp_q[i] <= REG_RST;
		end else begin
			if (c_we0)
				core_q[c_wa0] <= c_wd0;
			if (c_we1)
				core_q[c_wa1] <= c_wd1;
			if (f_we0)
				fp_q[f_wa0] <= f_wd0;
			if (f_we1)
				fp_q[f_wa1] <= f_wd1;
		end
	end

	// Data memory has no reset, as a RAM would not
	always_ff @(posedge clk) begin
		if (m_we)
			mem_q[m_wa] <= m_wd;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic go;
	assign go = st_q == st_exec && !skip;

	pair_write_a: assert property (go && op == op_pair_xfer && !dir |=>
		fp_q[$past(ra_p1)] == $past(rt2_val) && fp_q[$past(ra)] == $past(rt_val))
		else $error("pair transfer wrote wrong singles");
	dbl_low_a: assert property (go && op == op_dbl_xfer && !dir && rt != rt2 |=>
		fp_q[$past(dlo)] == $past(rt_val) && fp_q[$past(dhi)] == $past(rt2_val))
		else $error("double transfer word order wrong");
	half_keep_a: assert property (go && op == op_scalar_xfer && !dir |=>
		fp_q[$past(keep_half)] == $past(fp_q[keep_half]))
		else $error("scalar write disturbed other half");
	flag_copy_a: assert property (go && op == op_fp_status_read && rt == FLAG_TARGET |=>
		apsr_q == $past(fp_status_control_reg_q[31:28]))
		else $error("flag form did not copy flags");
	flags_hold_a: assert property (!(go && op == op_fp_status_read && rt == FLAG_TARGET)
		|=> $stable(apsr_q))
		else $error("application flags changed");
	status_load_a: assert property (go && op == op_fp_status_write |=>
		fp_status_control_reg_q == $past(rt_val))
		else $error("status write lost");
	sign_flip_a: assert property (go && op == op_fp_negate |=>
		fp_q[$past(ra)] == {~$past(sc_val[31]), $past(sc_val[30:0])})
		else $error("negate wrong");
	arith_bound_a: assert property (st_q == st_exec && ar_if.start |->
		##[1:27] st_q == st_idle)
		else $error("arithmetic did not finish");
	store_up_a: assert property (go && op == op_fp_store_multiple && !dec_b && list_ok
		|=> addr_q == $past(base_val) && st_q == st_mem)
		else $error("increment-after start wrong");
	store_down_a: assert property (go && down && list_ok |=>
		addr_q + {24'h0, cnt_q, 2'b00} == $past(base_val))
		else $error("decrement-before end wrong");
	skip_quiet_a: assert property (st_q == st_exec && skip |=>
		st_q == st_idle && $stable(fp_status_control_reg_q) && $stable(apsr_q))
		else $error("skipped command had effect");
	mem_cover_c: cover property (st_q == st_mem ##1 st_q == st_idle);
	arith_cover_c: cover property (st_q == st_arith && ar_if.done);
	flag_cover_c: cover property (go && op == op_fp_status_read && rt == FLAG_TARGET);
endmodule
`default_nettype wire

// >>> verilog/fmasu_unused.sv
`timescale 1ns/1ps

// >>> testbench/fmasu_host_model.sv
/*
 Avalon-MM master standing in for the instruction stream.
 Assumes the slave drops waitrequest when done; the bench times out hangs.
*/
`timescale 1ns/1ps
`default_nettype none
module fmasu_host_model (
	input  wire logic        clk,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	// Idle bus at time zero
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
	end
	// One transfer; a cycle gap before it keeps release and launch apart
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		// Waitrequest is sampled at each rising edge; data taken where it is low
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench/fmasu_top_test.sv
/*
 Self-checking bench of the unit against an array model of its registers.
 Assumes MEM_WORDS of 64, so byte address bits 7:2 index memory.
*/
`timescale 1ns/1ps
`default_nettype none
module fmasu_top_test;
	import fmasu_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [4:0]  adr;
	logic        rd_s, wr_s, wait_s;
	logic [31:0] wd, rdat, q, seed;
	logic [31:0] core [16];
	logic [31:0] fps [32];
	int          n_errors = 0, samples_checked = 0, cyc = 0;
	logic [31:0] res [5] = '{32'h4100_0000, 32'hc100_0000, 32'hc180_0000,
		32'h4180_0000, 32'h4000_0000};
	fmasu_op_t   aops [5] = '{op_fp_multiply, op_fp_neg_multiply,
		op_fp_neg_multiply_add, op_fp_neg_multiply_sub, op_fp_square_root};
	logic [4:0]  dst [5] = '{5'd12, 5'd13, 5'd12, 5'd13, 5'd16};

	// Clock and cycle ceiling
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	fmasu_top #(.MEM_WORDS(64)) uut (.clk(clk), .arst_n(arst_n), .avs_address(adr),
		.avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rdat), .avs_waitrequest(wait_s));
	fmasu_host_model host (.clk(clk), .avs_address(adr), .avs_read(rd_s),
		.avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wait_s));

	task automatic complete_run();
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask
	task automatic sets(input int i, input logic [31:0] v);
		wr(OFS_IDX, i);
		wr(OFS_FPR, v);
		fps[i] = v;
	endtask
	task automatic chks(input int i);
		wr(OFS_IDX, i);
		rd(OFS_FPR);
		check(q, fps[i]);
	endtask
	task automatic chkc(input int i);
		wr(OFS_IDX, i);
		rd(OFS_CORE);
		check(q, core[i]);
	endtask
	task automatic chkm(input int i, input logic [31:0] v);
		wr(OFS_IDX, i);
		rd(OFS_MEM);
		check(q, v);
	endtask
	// Issue a command, then poll until the unit is idle again
	task automatic run(input logic [31:0] c);
		wr(OFS_CMD, c);
		do rd(OFS_STAT); while (q[STAT_BUSY] !== 1'b0);
	endtask
	function automatic logic [31:0] cmd(input logic [3:0] op, input logic [4:0] ra,
		input logic [4:0] rc, input logic [3:0] rt, input logic [3:0] rt2,
		input logic [3:0] hi, input logic sk);
		return {hi, rt2, rt, rc, 5'd10, ra, sk, op};
	endfunction
	// Galois shift register for random core contents
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
	endfunction

	// Main sequence
	initial begin
		seed = 32'h0001_1c2c;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 32; i++) fps[i] = REG_RST;
		rd(OFS_FP_STATUS_CONTROL_REG);
		check(q, FP_STATUS_CONTROL_REG_RST);
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			core[i] = seed;
			wr(OFS_IDX, i);
			wr(OFS_CORE, seed);
		end
		// core operands avoid SP and PC
		run(cmd(op_pair_xfer, 5'd5, 5'd0, 4'd3, 4'd9, 4'h0, 1'b0));
		fps[5] = core[3];
		fps[6] = core[9];
		chks(5);
		chks(6);
		run(cmd(op_pair_xfer, 5'd5, 5'd0, 4'd1, 4'd0, 4'h8, 1'b0));
		core[1] = fps[5];
		core[0] = fps[6];
		chkc(1);
		chkc(0);
		run(cmd(op_dbl_xfer, 5'd7, 5'd0, 4'd2, 4'd4, 4'h0, 1'b0));
		fps[14] = core[2];
		fps[15] = core[4];
		chks(14);
		chks(15);
		for (int x = 0; x < 2; x++) begin
			run(cmd(op_scalar_xfer, 5'd7, 5'd0, 4'(5 + x), 4'd0, 4'(x), 1'b0));
			fps[14 + x] = core[5 + x];
			chks(14);
			chks(15);
		end
		run(cmd(op_fp_status_write, 5'd0, 5'd0, 4'd8, 4'd0, 4'h0, 1'b0));
		rd(OFS_FP_STATUS_CONTROL_REG);
		check(q, core[8]);
		run(cmd(op_fp_status_read, 5'd0, 5'd0, 4'd2, 4'd0, 4'h0, 1'b0));
		core[2] = core[8];
		chkc(2);
		rd(OFS_STAT);
		check({28'h0, q[7:4]}, 32'h0000_0000);
		run(cmd(op_fp_status_read, 5'd0, 5'd0, FLAG_TARGET, 4'd0, 4'h0, 1'b0));
		rd(OFS_STAT);
		check({28'h0, q[7:4]}, {28'h0, core[8][31:28]});
		// Skipped negate first, then the live one
		run(cmd(op_fp_negate, 5'd20, 5'd14, 4'd0, 4'd0, 4'h0, 1'b1));
		chks(20);
		run(cmd(op_fp_negate, 5'd20, 5'd14, 4'd0, 4'd0, 4'h0, 1'b0));
		fps[20] = fps[14] ^ 32'h8000_0000;
		chks(20);
		// Exact operands 2.0 and 4.0 keep every result free of rounding
		sets(10, 32'h4000_0000);
		sets(11, 32'h4080_0000);
		for (int k = 0; k < 5; k++) begin
			run(cmd(aops[k], dst[k], 5'd11, 4'd0, 4'd0, 4'h0, 1'b0));
			fps[dst[k]] = res[k];
			chks(dst[k]);
		end
		// single-width list of two, base not PC
		run(cmd(op_fp_store_multiple, 5'd12, 5'd2, 4'd12, 4'd0, 4'h0, 1'b0));
		chkm(int'(core[12][7:2]), fps[12]);
		chkm(int'(core[12][7:2]) + 1, fps[13]);
		run(cmd(op_fp_store_multiple, 5'd12, 5'd2, 4'd11, 4'd0, 4'h6, 1'b0));
		core[11] = core[11] - 32'h0000_0008;
		chkc(11);
		chkm(int'(core[11][7:2]) + 1, fps[13]);
		// Empty and oversized lists are refused with the error bit
		for (int x = 0; x < 2; x++) begin
			run(cmd(op_fp_store_multiple, 5'd12, 5'(17 * x), 4'd12, 4'd0, 4'h0, 1'b0));
			check({31'h0, q[STAT_ERR]}, 32'h0000_0001);
		end
		chkc(12);
		run(cmd(op_fp_stack_push, 5'd16, 5'd1, 4'd0, 4'd0, 4'h0, 1'b0));
		run(cmd(op_fp_stack_pop, 5'd21, 5'd1, 4'd0, 4'd0, 4'h0, 1'b0));
		fps[21] = fps[16];
		chks(21);
		chkc(13);
		complete_run();
	end
endmodule
`default_nettype wire
